// ==== src/ectr_pkg.sv ====
// Overview of operation
// - counting down, one underflow per reload value plus one counted events.
// - counting begins when software sets the start flag to one.
// - clearing the start flag stops counting and holds the count.
// - each overflow (up) or underflow (down) raises an interrupt request.
// - event input pin is either general-purpose I/O or the count source.
// - output pin is general-purpose I/O, pulse output, or up/down select input.
// - reading the counter register returns the current count.
// - writing the counter while stopped loads both reload register and counter.
// - writing the counter while running loads only the reload register.
// - counting up, one overflow per 0xffff minus reload plus one events.
// - on overflow or underflow the counter reloads and keeps counting.
// - a reload value written while running enters the counter at next reload.
// - software selects the active edge of the external count input.
package ectr_pkg;

  localparam int AXI_AW = 8;
  localparam int CNT_W = 16;

  // register byte addresses
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_COUNT = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_RELOAD = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h0c;
  localparam logic [AXI_AW-1:0] ADDR_MASK = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_GPIO = 8'h14;

  localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // status and mask bit positions
  localparam int STS_OVF = 0;
  localparam int STS_UNF = 1;

  // gpio register bit positions
  localparam int GPIO_IN_OUT = 0;
  localparam int GPIO_OUT_OUT = 1;
  localparam int GPIO_IN_DRV = 2;
  localparam int GPIO_OUT_DRV = 3;
  localparam int GPIO_LVL_LO = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ECTR_EDGE_RISE = 2'b00,
    ECTR_EDGE_FALL = 2'b01,
    ECTR_EDGE_BOTH = 2'b11
  } ectr_edge_t;

  typedef enum logic [1:0] {
    ECTR_OUT_GPIO = 2'b00,
    ECTR_OUT_PULSE = 2'b01,
    ECTR_OUT_DIR_IN = 2'b11
  } ectr_out_t;

  // control register, bit 0 is start
  typedef struct packed {
    ectr_out_t out_mode;   // [6:5]
    logic in_src;          // [4]
    ectr_edge_t edge_sel;  // [3:2]
    logic down;            // [1]
    logic start;           // [0]
  } ectr_ctrl_t;

  localparam int CTRL_W = 7;

  typedef struct packed {
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ectr_ctrl_t ctrl;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] reload;
    logic [1:0] sts;
    logic [1:0] mask;
    logic [3:0] gpio;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic pulse;
  } ectr_state_t;

  localparam ectr_state_t ECTR_STATE_RESET = '0;

endpackage

// ==== src/ectr_top.sv ====
`timescale 1ns/1ns
module ectr_top import ectr_pkg::*; (
  input wire logic SYS_CLK,                   // 20 MHz system clock
  input wire logic RST_B,                     // async reset, active low
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID,             // write address valid
  output logic S_AXI_AWREADY,                 // write address ready
  input wire logic [31:0] S_AXI_WDATA,        // write data
  input wire logic [3:0] S_AXI_WSTRB,         // write byte strobes
  input wire logic S_AXI_WVALID,              // write data valid
  output logic S_AXI_WREADY,                  // write data ready
  output logic [1:0] S_AXI_BRESP,             // write response
  output logic S_AXI_BVALID,                  // write response valid
  input wire logic S_AXI_BREADY,              // write response ready
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID,             // read address valid
  output logic S_AXI_ARREADY,                 // read address ready
  output logic [31:0] S_AXI_RDATA,            // read data
  output logic [1:0] S_AXI_RRESP,             // read response
  output logic S_AXI_RVALID,                  // read data valid
  input wire logic S_AXI_RREADY,              // read data ready
  input wire logic EVT_IN_I,                  // event input pin level
  output logic EVT_IN_O,                      // event input pin drive value
  output logic EVT_IN_OE_B,                   // event input pin drive enable, low drives
  input wire logic EVT_OUT_I,                 // event output pin level
  output logic EVT_OUT_O,                     // event output pin drive value
  output logic EVT_OUT_OE_B,                  // event output pin drive enable, low drives
  output logic IRQ                            // level interrupt
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ectr_state_t s;
  ectr_state_t next_s;
  logic rise;
  logic fall;
  logic edge_hit;
  logic ev;
  logic up;
  logic wrap;
  logic wr_fire;
  logic [31:0] mrg_ctrl;
  logic [31:0] mrg_cnt;
  logic [31:0] mrg_reload;
  logic [31:0] mrg_mask;
  logic [31:0] mrg_gpio;
  logic [1:0] evt;
  logic [1:0] clr;

  // stage 3 is only an edge history, the pins are read from stage 2
  assign rise = s.sync2[0] & ~s.sync3[0];
  assign fall = ~s.sync2[0] & s.sync3[0];

  always_comb begin
    unique case (s.ctrl.edge_sel)
      ECTR_EDGE_RISE: edge_hit = rise;
      ECTR_EDGE_FALL: edge_hit = fall;
      ECTR_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = rise;
    endcase
  end

  // pin counts only while it is the count source and the start flag is set
  assign ev = s.ctrl.start & s.ctrl.in_src & edge_hit;
  // pin high selects up when the output pin is the direction input
  assign up = (s.ctrl.out_mode == ECTR_OUT_DIR_IN) ? s.sync2[1] : ~s.ctrl.down;
  assign wrap = up ? (s.cnt == CNT_FULL) : (s.cnt == CNT_ZERO);
  assign evt = {ev & wrap & ~up, ev & wrap & up};

  assign wr_fire = s.aw_got & s.w_got & ~s.bvalid;
  // merged words are full width, each register keeps only its own low bits
  assign mrg_ctrl = merge_bytes({25'h0, s.ctrl}, s.wdata, s.wstrb);
  assign mrg_cnt = merge_bytes({16'h0, s.cnt}, s.wdata, s.wstrb);
  assign mrg_reload = merge_bytes({16'h0, s.reload}, s.wdata, s.wstrb);
  assign mrg_mask = merge_bytes({30'h0, s.mask}, s.wdata, s.wstrb);
  assign mrg_gpio = merge_bytes({28'h0, s.gpio}, s.wdata, s.wstrb);
  assign clr = (wr_fire && s.aw_addr == ADDR_STATUS) ? s.wdata[1:0] & {2{s.wstrb[0]}} : 2'b00;

  always_comb begin
    next_s = s;
    next_s.sync1 = {EVT_OUT_I, EVT_IN_I};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;

    // write channels are taken independently, the write acts once both are held
    if (S_AXI_AWVALID && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.wdata = S_AXI_WDATA;
      next_s.wstrb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // count path; reload uses the value held before any same-cycle write
    if (ev) begin
      if (wrap) begin
        next_s.cnt = s.reload;
        next_s.pulse = ~s.pulse;
      end else if (up) begin
        next_s.cnt = s.cnt + 16'h0001;
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end

    if (wr_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        ADDR_CTRL: begin
          next_s.ctrl = ectr_ctrl_t'(mrg_ctrl[CTRL_W-1:0]);
        end
        ADDR_COUNT: begin
          next_s.reload = mrg_reload[CNT_W-1:0];
          if (!s.ctrl.start) begin
            next_s.cnt = mrg_cnt[CNT_W-1:0];
          end
        end
        ADDR_STATUS: begin
        end
        ADDR_MASK: begin
          next_s.mask = mrg_mask[1:0];
        end
        ADDR_GPIO: begin
          next_s.gpio = mrg_gpio[3:0];
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // an event in the clearing cycle survives
    next_s.sts = (s.sts & ~clr) | evt;

    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (S_AXI_ARADDR)
        ADDR_CTRL: next_s.rdata = {25'h0, s.ctrl};
        ADDR_COUNT: next_s.rdata = {16'h0, s.cnt};
        ADDR_RELOAD: next_s.rdata = {16'h0, s.reload};
        ADDR_STATUS: next_s.rdata = {30'h0, s.sts};
        ADDR_MASK: next_s.rdata = {30'h0, s.mask};
        ADDR_GPIO: next_s.rdata = {26'h0, s.sync2, s.gpio};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= ECTR_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY = ~s.aw_got;
  assign S_AXI_WREADY = ~s.w_got;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = ~s.rvalid;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;

  // input pin is never driven while it is the count source
  assign EVT_IN_O = s.gpio[GPIO_IN_OUT];
  assign EVT_IN_OE_B = ~(s.gpio[GPIO_IN_DRV] & ~s.ctrl.in_src);
  assign EVT_OUT_O = (s.ctrl.out_mode == ECTR_OUT_PULSE) ? s.pulse : s.gpio[GPIO_OUT_OUT];
  assign EVT_OUT_OE_B = ~((s.ctrl.out_mode == ECTR_OUT_PULSE) |
                          ((s.ctrl.out_mode == ECTR_OUT_GPIO) & s.gpio[GPIO_OUT_DRV]));
  assign IRQ = |(s.sts & s.mask);

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  property p_down_underflow;
    ev && !up && s.cnt == CNT_ZERO && !wr_fire |=> s.cnt == $past(s.reload) && s.sts[STS_UNF];
  endproperty
  a_down_underflow: assert property (p_down_underflow) else $error("underflow did not reload");

  property p_up_overflow;
    ev && up && s.cnt == CNT_FULL && !wr_fire |=> s.cnt == $past(s.reload) && s.sts[STS_OVF];
  endproperty
  a_up_overflow: assert property (p_up_overflow) else $error("overflow did not reload");

  property p_down_step;
    ev && !up && s.cnt != CNT_ZERO && !wr_fire |=> s.cnt == $past(s.cnt) - 16'h0001;
  endproperty
  a_down_step: assert property (p_down_step) else $error("count did not step");

  property p_hold_stopped;
    !s.ctrl.start && !wr_fire |=> s.cnt == $past(s.cnt);
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("stopped count moved");

  // a mask write in the same cycle may legally hide the request
  property p_irq_level;
    ev && wrap && (up ? s.mask[STS_OVF] : s.mask[STS_UNF])
      && !(wr_fire && s.aw_addr == ADDR_MASK) |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("event flag lost");

  property p_read_count;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_COUNT
      |=> S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(s.cnt);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

  property p_write_stopped;
    wr_fire && s.aw_addr == ADDR_COUNT && !s.ctrl.start && s.wstrb == 4'hf
      |=> s.cnt == $past(s.wdata[15:0]) && s.reload == $past(s.wdata[15:0]);
  endproperty
  a_write_stopped: assert property (p_write_stopped) else $error("stopped write lost");

  property p_write_running;
    wr_fire && s.aw_addr == ADDR_COUNT && s.ctrl.start && !ev && s.wstrb == 4'hf
      |=> s.cnt == $past(s.cnt) && s.reload == $past(s.wdata[15:0]);
  endproperty
  a_write_running: assert property (p_write_running) else $error("running write hit count");

  property p_edge_sel;
    s.ctrl.edge_sel == ECTR_EDGE_FALL && rise |-> !ev;
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("wrong edge counted");

  property p_sync_once;
    ev |=> !ev || s.ctrl.edge_sel == ECTR_EDGE_BOTH;
  endproperty
  a_sync_once: assert property (p_sync_once) else $error("edge counted twice");

  property p_pin_src;
    s.ctrl.in_src |-> EVT_IN_OE_B;
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("source pin driven");

  property p_pulse_toggle;
    s.ctrl.out_mode == ECTR_OUT_PULSE && ev && wrap && !wr_fire
      |=> EVT_OUT_O != $past(EVT_OUT_O);
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse did not toggle");

  property p_up_step;
    ev && up && s.cnt != CNT_FULL && !wr_fire |=> s.cnt == $past(s.cnt) + 16'h0001;
  endproperty
  a_up_step: assert property (p_up_step) else $error("count did not step up");

  // the flag must outlive every cycle in which software does not clear it
  property p_sts_sticky;
    s.sts[STS_UNF] && !clr[STS_UNF] |=> s.sts[STS_UNF];
  endproperty
  a_sts_sticky: assert property (p_sts_sticky) else $error("status flag dropped");

  property p_set_wins;
    evt != 2'b00 |=> (s.sts & $past(evt)) == $past(evt);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_w1c_clear;
    clr[STS_OVF] && !evt[STS_OVF] |=> !s.sts[STS_OVF];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("status flag not cleared");

  property p_no_src_count;
    !s.ctrl.in_src && !wr_fire |=> s.cnt == $past(s.cnt);
  endproperty
  a_no_src_count: assert property (p_no_src_count) else $error("gpio pin counted");

  property p_gpio_in_drive;
    !s.ctrl.in_src && s.gpio[GPIO_IN_DRV] |-> !EVT_IN_OE_B && EVT_IN_O == s.gpio[GPIO_IN_OUT];
  endproperty
  a_gpio_in_drive: assert property (p_gpio_in_drive) else $error("gpio drive lost");

  // a low direction pin must count down even with the control bit set to up
  property p_dir_down;
    ev && s.ctrl.out_mode == ECTR_OUT_DIR_IN && !s.sync2[1] && s.cnt != CNT_ZERO && !wr_fire
      |=> s.cnt == $past(s.cnt) - 16'h0001;
  endproperty
  a_dir_down: assert property (p_dir_down) else $error("direction pin ignored");

  property p_dir_released;
    s.ctrl.out_mode == ECTR_OUT_DIR_IN |-> EVT_OUT_OE_B;
  endproperty
  a_dir_released: assert property (p_dir_released) else $error("dir pin driven");

  property p_idle_pulse;
    !s.ctrl.start && s.ctrl.out_mode == ECTR_OUT_PULSE && !wr_fire |=> $stable(EVT_OUT_O);
  endproperty
  a_idle_pulse: assert property (p_idle_pulse) else $error("idle pulse moved");

  property p_read_reload;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_RELOAD
      |=> S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(s.reload);
  endproperty
  a_read_reload: assert property (p_read_reload) else $error("reload read wrong");

  // reload is read-only over the bus and is answered as unmapped
  property p_bresp_unmapped;
    wr_fire && s.aw_addr == ADDR_RELOAD
      |=> S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR && s.reload == $past(s.reload);
  endproperty
  a_bresp_unmapped: assert property (p_bresp_unmapped) else $error("bad write response");

  property p_rresp_unmapped;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h18
      |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000;
  endproperty
  a_rresp_unmapped: assert property (p_rresp_unmapped) else $error("bad read response");

  c_underflow: cover property (ev && !up && wrap);
  c_overflow: cover property (ev && up && wrap);
  c_write_running: cover property (wr_fire && s.aw_addr == ADDR_COUNT && s.ctrl.start);
  c_irq: cover property (IRQ);
  c_pulse_wrap: cover property (s.ctrl.out_mode == ECTR_OUT_PULSE && ev && wrap);

endmodule // ectr_top

// ==== verification/ectr_evt_src.sv ====
`timescale 1ns/1ns
module ectr_evt_src (
  input wire logic clk, // system clock
  output logic lvl      // event line level
);
  initial lvl = 1'b0;

  // high three cycles, low at least three, so no edge is lost in the sync
  task pulses(input int k);
    repeat (k) begin
      @(posedge clk);
      lvl <= 1'b1;
      repeat (3) @(posedge clk);
      lvl <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // ectr_evt_src

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb import ectr_pkg::*; ;
  logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, dir = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, r;
  logic [1:0] rs;
  logic [3:0] ws = 0;
  logic p;
  wire awr, wrd, bv, arr, rv, irq, io, ioe, oo, ooe, src;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire pin_in = !ioe ? io : src;
  wire pin_out = !ooe ? oo : dir;
  int n_mismatch = 0, n_checks = 0, n, m, e, k;

  initial forever #25 clk = ~clk;

  ectr_evt_src i_src (.clk(clk), .lvl(src));
  ectr_top i_dut (.SYS_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .EVT_IN_I(pin_in),
    .EVT_IN_O(io), .EVT_IN_OE_B(ioe), .EVT_OUT_I(pin_out), .EVT_OUT_O(oo),
    .EVT_OUT_OE_B(ooe), .IRQ(irq));

  // events per wrap for a given reload and direction
  function automatic int evts(input bit down, input int v);
    return down ? v + 1 : 'hffff - v + 1;
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // handshakes are judged on the rising edge, with the values that stood before it
  task wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= st;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    forever begin
      @(posedge clk);
      if (awr && awv) awv <= 0;
      if (wrd && wv) wv <= 0;
      if (bv && bre) begin
        rs = br;
        bre <= 0;
        break;
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    wrs(a, d, 4'hf);
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    forever begin
      @(posedge clk);
      if (arr && arv) arv <= 0;
      if (rv && rre) begin
        r = rdat;
        rs = rr;
        rre <= 0;
        break;
      end
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #3000000;
    n_mismatch++;
    print_verdict;
  end

  initial begin
    n = $urandom(72453);
    repeat (4) @(posedge clk);
    rst_b <= 1;
    rd(ADDR_COUNT);
    chk(r, 0);
    rd(8'h18);
    chk(rs, RESP_SLVERR);
    n = $urandom_range(2, 9);
    wr(ADDR_COUNT, n);
    rd(ADDR_COUNT);
    chk(r, n);
    rd(ADDR_RELOAD);
    chk(r, n);
    wr(ADDR_MASK, 3);
    wr(ADDR_CTRL, 'h13);
    i_src.pulses(evts(1, n) - 1);
    rd(ADDR_STATUS);
    chk(r, 0);
    chk(irq, 0);
    i_src.pulses(1);
    rd(ADDR_STATUS);
    chk(r, 2);
    chk(irq, 1);
    rd(ADDR_COUNT);
    chk(r, n);
    m = $urandom_range(2, 9);
    wr(ADDR_COUNT, m);
    rd(ADDR_COUNT);
    chk(r, n);
    rd(ADDR_RELOAD);
    chk(r, m);
    wr(ADDR_STATUS, 3);
    chk(irq, 0);
    i_src.pulses(evts(1, n));
    rd(ADDR_COUNT);
    chk(r, m);
    wr(ADDR_CTRL, 'h12);
    i_src.pulses(2);
    rd(ADDR_COUNT);
    chk(r, m);
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? 0 : (i == 1) ? 1 : 3;
      wr(ADDR_COUNT, 'h100);
      wr(ADDR_CTRL, 'h13 | (e << 2));
      i_src.pulses(2);
      wr(ADDR_CTRL, 'h12);
      rd(ADDR_COUNT);
      chk(r, (e == 3) ? 'hfc : 'hfe);
    end
    n = 17'h10000 - $urandom_range(1, 3);
    wr(ADDR_COUNT, n);
    wr(ADDR_STATUS, 3);
    wr(ADDR_CTRL, 'h11);
    i_src.pulses(evts(0, n) - 1);
    rd(ADDR_STATUS);
    chk(r, 0);
    i_src.pulses(1);
    rd(ADDR_STATUS);
    chk(r, 1);
    rd(ADDR_COUNT);
    chk(r, n);
    wr(ADDR_CTRL, 'h10);
    wr(ADDR_COUNT, 'h50);
    dir <= 1;
    wr(ADDR_CTRL, 'h73);
    chk(ooe, 1);
    i_src.pulses(1);
    wr(ADDR_CTRL, 'h32);
    chk(ooe, 0);
    rd(ADDR_COUNT);
    chk(r, 'h51);
    wr(ADDR_CTRL, 'h00);
    wr(ADDR_GPIO, 'h5);
    chk({ioe, io}, 1);
    rd(ADDR_GPIO);
    chk(r[4], 1);
    wr(ADDR_GPIO, 0);
    wr(ADDR_CTRL, 'h03);
    i_src.pulses(2);
    rd(ADDR_COUNT);
    chk(r, 'h51);
    k = $urandom;
    wr(ADDR_CTRL, 'h00);
    wrs(ADDR_COUNT, k, 4'h2);
    rd(ADDR_COUNT);
    chk(r, {k[15:8], 8'h51});
    rd(ADDR_RELOAD);
    chk(r, {k[15:8], 8'h50});
    wr(ADDR_RELOAD, k);
    chk(rs, RESP_SLVERR);
    rd(ADDR_RELOAD);
    chk(r, {k[15:8], 8'h50});
    wr(ADDR_COUNT, 1);
    wr(ADDR_CTRL, 'h33);
    p = oo;
    i_src.pulses(2);
    chk(oo, !p);
    rd(ADDR_COUNT);
    chk(r, 1);
    dir <= 0;
    wr(ADDR_CTRL, 'h71);
    chk(ooe, 1);
    i_src.pulses(1);
    wr(ADDR_CTRL, 'h10);
    rd(ADDR_COUNT);
    chk(r, 0);
    print_verdict;
  end
endmodule // tb
